// >>> ssidr_chan_if.sv
// Purpose: Link between the register core and one transfer channel
// Assumes: Single clock domain
// Notes: ctrl side drives loads, trigger and ack; chan side drives state
`timescale 1ns/1ns
interface ssidr_chan_if;
  logic ptrWe;
  logic cntWe;
  logic [31:0] wrData;
  logic trigger;
  logic ack;
  logic [31:0] ptr;
  logic [15:0] cnt;
  logic req;
  logic done;
  modport ctrl (output ptrWe, cntWe, wrData, trigger, ack, input ptr, cnt, req, done);
  modport chan (input ptrWe, cntWe, wrData, trigger, ack, output ptr, cnt, req, done);
endinterface

// >>> ssidr_core.sv
// Purpose: Status flags, interrupt mask, data registers and two transfer channels
// Assumes: Classic Wishbone slave; serializer strobes on core_clk
// Notes: One ack per request, one cycle after the request is seen
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
//
// Contract
// R1: Software writes transmit words right-aligned; unused upper bits ignored.
// R2: Per-word select code used only with variable select in master mode.
// R3: Without external decode, code gives one active-low select line; 1111 none.
// R4: With external decode, select lines equal the code directly.
// R5: Status bit 16 reads one while the unit is enabled.
// R6: Receive-full sets on serializer load, clears on receive register read.
// R7: Transmit-empty clears on transmit write, sets when serializer takes word.
// R8: Transmit-empty is zero at reset and while disabled; enable sets it.
// R9: Mode-fault flag sets on fault, clears on status register read.
// R10: Overrun sets on second load without read, clears on status read.
// R11: Receive buffer-done bit follows receive channel end of transfer.
// R12: Transmit buffer-done bit follows transmit channel end of transfer.
// R13: Writing ones to enable register enables those interrupts; zeros no effect.
// R14: Writing ones to disable register disables those interrupts; zeros no effect.
// R15: Mask register reads one for each enabled interrupt.
// R16: Receive pointer holds receive buffer address, loaded by software first.
// R17: Receive count zero stops; nonzero moves data while receive-full is active.
// R18: Each transfer decrements count, increments pointer; zero ends and holds.
// R19: Transmit channel moves data while transmit-empty and count is nonzero.
// R20: Interrupt output high while any enabled flag is set.
// R21: In master mode an active primary select input is a mode fault; the code flags only its high-to-low transition, and only while enabled.
module ssidr_core (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] wbAdr,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  input wire logic wbWe,
  input wire logic [3:0] wbSel,
  input wire logic wbCyc,
  input wire logic wbStb,
  output logic wbAck,
  output logic [31:0] serTxWord,
  output logic serTxValid,
  input wire logic serTxTaken,
  input wire logic serRxValid,
  input wire logic [15:0] serRxData,
  output logic [3:0] selectLines,
  output logic selectOen,
  input wire logic primarySelectInN,
  output logic irq,
  output logic rxReq,
  output logic [31:0] rxAddr,
  output logic [31:0] rxWord,
  input wire logic rxAck,
  output logic txReq,
  output logic [31:0] txAddr,
  input wire logic txAck,
  input wire logic [31:0] txData
);
  logic enabled;
  logic masterMode;
  logic varSelect;
  logic extDecode;
  logic [3:0] fixedCode;
  logic [31:0] txWord;
  logic rxFull;
  logic txEmpty;
  logic modeFault;
  logic overrun;
  logic [5:0] irqMask;
  logic [5:0] flags;
  logic [31:0] statusWord;
  logic [31:0] byteMask;
  logic [31:0] rdMux;
  logic reqLive;
  logic wrStrobe;
  logic rdStrobe;
  logic enCmd;
  logic disCmd;
  logic txWrite;
  logic txTake;
  logic rxLoad;
  logic rxClear;
  logic srRead;
  logic faultEvent;
  logic psMeta;
  logic psSync;
  logic psPrev;
  logic [3:0] selCode;
  logic [3:0] next_selectLines;
  logic [31:0] maskedWr;

  ssidr_chan_if rxIf ();
  ssidr_chan_if txIf ();

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byteMask[8*i +: 8] = wbSel[i] ? 8'hFF : 8'h00;
    end
  end

  assign reqLive = wbCyc && wbStb;
  assign wrStrobe = reqLive && wbAck && wbWe;
  assign rdStrobe = reqLive && wbAck && !wbWe;
  assign maskedWr = wbDatI & byteMask;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wbAck <= 1'b0;
    end else begin
      wbAck <= reqLive && !wbAck;
    end
  end

  assign flags[ssidr_pkg::FLAG_RXFULL] = rxFull;
  assign flags[ssidr_pkg::FLAG_TXEMPTY] = txEmpty;
  assign flags[ssidr_pkg::FLAG_MODEFAULT] = modeFault;
  assign flags[ssidr_pkg::FLAG_OVERRUN] = overrun;
  assign flags[ssidr_pkg::FLAG_RXDONE] = rxIf.done; // see R11
  assign flags[ssidr_pkg::FLAG_TXDONE] = txIf.done; // see R12

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[5:0] = flags;
    statusWord[ssidr_pkg::STAT_ENABLED] = enabled; // see R5
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    case (wbAdr)
      ssidr_pkg::OFF_MODE: begin
        rdMux[ssidr_pkg::MODE_MASTER] = masterMode;
        rdMux[ssidr_pkg::MODE_VARSEL] = varSelect;
        rdMux[ssidr_pkg::MODE_EXTDEC] = extDecode;
        rdMux[ssidr_pkg::MODE_CODE_LSB +: 4] = fixedCode;
      end
      ssidr_pkg::OFF_RXWORD: rdMux = rxWord;
      ssidr_pkg::OFF_STATUS: rdMux = statusWord;
      ssidr_pkg::OFF_IRQMASK: rdMux[5:0] = irqMask; // see R15
      ssidr_pkg::OFF_RXADDR: rdMux = rxIf.ptr;
      ssidr_pkg::OFF_RXCOUNT: rdMux[15:0] = rxIf.cnt;
      ssidr_pkg::OFF_TXADDR: rdMux = txIf.ptr;
      ssidr_pkg::OFF_TXCOUNT: rdMux[15:0] = txIf.cnt;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wbDatO <= 32'h0000_0000;
    end else if (reqLive && !wbAck) begin
      wbDatO <= rdMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable and mode

  assign enCmd = wrStrobe && (wbAdr == ssidr_pkg::OFF_CTRL) && maskedWr[ssidr_pkg::CTRL_ENABLE];
  assign disCmd = wrStrobe && (wbAdr == ssidr_pkg::OFF_CTRL) && maskedWr[ssidr_pkg::CTRL_DISABLE];

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      enabled <= 1'b0;
    end else if (disCmd) begin
      enabled <= 1'b0;
    end else if (enCmd) begin
      enabled <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      masterMode <= 1'b0;
      varSelect <= 1'b0;
      extDecode <= 1'b0;
      fixedCode <= ssidr_pkg::RST_CODE;
    end else if (wrStrobe && (wbAdr == ssidr_pkg::OFF_MODE)) begin
      if (wbSel[0]) begin
        masterMode <= wbDatI[ssidr_pkg::MODE_MASTER];
        varSelect <= wbDatI[ssidr_pkg::MODE_VARSEL];
        extDecode <= wbDatI[ssidr_pkg::MODE_EXTDEC];
      end
      if (wbSel[2]) begin
        fixedCode <= wbDatI[ssidr_pkg::MODE_CODE_LSB +: 4];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit word and transmit-empty flag

  assign txWrite = (wrStrobe && (wbAdr == ssidr_pkg::OFF_TXWORD)) || (txAck && txIf.req);
  assign serTxValid = enabled && !txEmpty;
  assign txTake = serTxTaken && serTxValid;
  assign serTxWord = txWord;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txWord <= ssidr_pkg::RST_WORD;
    end else if (txAck && txIf.req) begin
      txWord <= txData; // see R19
    end else if (wrStrobe && (wbAdr == ssidr_pkg::OFF_TXWORD)) begin
      txWord <= maskedWr | (txWord & ~byteMask);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txEmpty <= 1'b0; // see R8
    end else if (disCmd || (!enabled && !enCmd)) begin
      txEmpty <= 1'b0; // see R8
    end else if (enCmd && !enabled) begin
      txEmpty <= 1'b1; // see R8
    end else if (txWrite) begin
      txEmpty <= 1'b0; // see R7
    end else if (txTake) begin
      txEmpty <= 1'b1; // see R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive word, receive-full and overrun

  assign rxLoad = serRxValid && enabled;
  assign rxClear = (rdStrobe && (wbAdr == ssidr_pkg::OFF_RXWORD)) || (rxAck && rxIf.req);
  assign srRead = rdStrobe && (wbAdr == ssidr_pkg::OFF_STATUS);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxWord <= ssidr_pkg::RST_WORD;
    end else if (rxLoad) begin
      rxWord <= {12'h000, (masterMode ? selectLines : 4'h0), serRxData};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxFull <= 1'b0;
    end else if (rxLoad) begin
      rxFull <= 1'b1; // see R6
    end else if (rxClear) begin
      rxFull <= 1'b0; // see R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      overrun <= 1'b0;
    end else if (rxLoad && rxFull && !rxClear) begin
      overrun <= 1'b1; // see R10
    end else if (srRead) begin
      overrun <= 1'b0; // see R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode fault from primary select pin

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      psMeta <= 1'b1;
      psSync <= 1'b1;
      psPrev <= 1'b1;
    end else begin
      psMeta <= primarySelectInN;
      psSync <= psMeta;
      psPrev <= psSync;
    end
  end

  assign faultEvent = enabled && masterMode && psPrev && !psSync; // see R21

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      modeFault <= 1'b0;
    end else if (faultEvent) begin
      modeFault <= 1'b1; // see R9
    end else if (srRead) begin
      modeFault <= 1'b0; // see R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt mask and output

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irqMask <= ssidr_pkg::RST_MASK;
    end else if (wrStrobe && (wbAdr == ssidr_pkg::OFF_IRQEN)) begin
      irqMask <= irqMask | maskedWr[5:0]; // see R13
    end else if (wrStrobe && (wbAdr == ssidr_pkg::OFF_IRQDIS)) begin
      irqMask <= irqMask & ~maskedWr[5:0]; // see R14
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irqMask); // see R20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Select lines

  assign selCode = (masterMode && varSelect) ? txWord[ssidr_pkg::CODE_LSB +: 4] : fixedCode; // see R2

  ssidr_sel_decode u_decode (
    .code(selCode),
    .extDecode(extDecode),
    .lines(next_selectLines)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      selectLines <= ssidr_pkg::SEL_NONE;
      selectOen <= 1'b1;
    end else begin
      selectLines <= next_selectLines; // see R3 see R4
      selectOen <= !(enabled && masterMode);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer channels

  assign rxIf.ptrWe = wrStrobe && (wbAdr == ssidr_pkg::OFF_RXADDR);
  assign rxIf.cntWe = wrStrobe && (wbAdr == ssidr_pkg::OFF_RXCOUNT);
  assign rxIf.wrData = rxIf.cntWe ? (maskedWr | ({16'h0000, rxIf.cnt} & ~byteMask))
                                  : (maskedWr | (rxIf.ptr & ~byteMask));
  assign rxIf.trigger = rxFull; // see R17
  assign rxIf.ack = rxAck;
  assign txIf.ptrWe = wrStrobe && (wbAdr == ssidr_pkg::OFF_TXADDR);
  assign txIf.cntWe = wrStrobe && (wbAdr == ssidr_pkg::OFF_TXCOUNT);
  assign txIf.wrData = txIf.cntWe ? (maskedWr | ({16'h0000, txIf.cnt} & ~byteMask))
                                  : (maskedWr | (txIf.ptr & ~byteMask));
  assign txIf.trigger = txEmpty; // see R19
  assign txIf.ack = txAck;

  ssidr_dma_chan u_rxChan (
    .core_clk(core_clk),
    .resetn(resetn),
    .ch(rxIf)
  );

  ssidr_dma_chan u_txChan (
    .core_clk(core_clk),
    .resetn(resetn),
    .ch(txIf)
  );

  assign rxReq = rxIf.req;
  assign rxAddr = rxIf.ptr;
  assign txReq = txIf.req;
  assign txAddr = txIf.ptr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_first_load;
    rxLoad && !rxClear;
  endsequence

  sequence s_second_load;
    rxLoad && rxFull && !rxClear;
  endsequence

  a_wb_ack_once: assert property (reqLive && !wbAck |=> wbAck ##1 !wbAck)
    else $error("bus ack not a single cycle after request");
  a_rx_full_set: assert property (rxLoad |=> rxFull) // see R6
    else $error("receive-full not set on load");
  a_overrun_two_loads: assert property (s_first_load ##[1:5] s_second_load |=> overrun) // see R10
    else $error("overrun missed on second load");
  a_tx_empty_off: assert property (!enabled |-> !txEmpty) // see R8
    else $error("transmit-empty set while disabled");
  a_tx_write_clear: assert property (txWrite && enabled && !disCmd |=> !txEmpty) // see R7
    else $error("transmit-empty not cleared by write");
  a_fault_read_clear: assert property (srRead && !faultEvent |=> !modeFault) // see R9
    else $error("mode fault not cleared by status read");
  a_irq_enable_bit: assert property (wrStrobe && wbAdr == ssidr_pkg::OFF_IRQEN && maskedWr[0]
                                     |=> irqMask[0] ##1 (irq || !$past(rxFull))) // see R13 see R20
    else $error("interrupt enable did not take");
  a_irq_disable_bit: assert property (wrStrobe && wbAdr == ssidr_pkg::OFF_IRQDIS && maskedWr[1]
                                      |=> !irqMask[1]) // see R14
    else $error("interrupt disable did not take");
  a_fault_pin_set: assert property (faultEvent |=> modeFault) // see R21
    else $error("mode fault not flagged");
endmodule

// >>> ssidr_core_bench.sv
// Purpose: Self-checking bench for the status, mask and channel block
// Assumes: Far side model answers channels and serializer
// Notes: Registers reached by classic Wishbone tasks
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module ssidr_core_bench;
  logic core_clk = '0, resetn = '0, wbWe = '0, wbCyc = '0, wbStb = '0, serRxValid = '0;
  logic serOn = '0, primarySelectInN = '1;
  logic serTxValid, serTxTaken, wbAck, selectOen, irq, rxReq, rxAck, txReq, txAck;
  logic [7:0] wbAdr = '0;
  logic [3:0] wbSel = '0, lag = '0, selectLines;
  logic [15:0] serRxData = '0;
  logic [31:0] wbDatI = '0, wbDatO, serTxWord, rxAddr, rxWord, txAddr, txData, q;
  int miscompares = 0, checked = 0, cycles = 0;

  ssidr_core i_ssidr_core (
    .core_clk, .resetn, .wbAdr, .wbDatI, .wbDatO, .wbWe, .wbSel, .wbCyc, .wbStb, .wbAck,
    .serTxWord, .serTxValid, .serTxTaken, .serRxValid, .serRxData, .selectLines,
    .selectOen, .primarySelectInN, .irq, .rxReq, .rxAddr, .rxWord, .rxAck, .txReq,
    .txAddr, .txAck, .txData
  );
  ssidr_far_model i_ssidr_far_model (
    .core_clk, .resetn, .lag, .serOn, .rxReq, .rxAck, .txReq, .txAck, .txData,
    .serTxValid, .serTxTaken
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog, verdict
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic conclude();
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Bus and stimulus helpers
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    wbAdr <= a;
    wbWe <= w;
    wbDatI <= d;
    wbSel <= 4'hF;
    wbCyc <= 1'h1;
    wbStb <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'h1);
    q = wbDatO;
    wbCyc <= 1'h0;
    wbStb <= 1'h0;
    wbWe <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(a, 1'h0, 32'h0000_0000);
    `CHK(q, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pulse(input logic [15:0] d);
    @(posedge core_clk);
    serRxValid <= 1'h1;
    serRxData <= d;
    @(posedge core_clk);
    serRxValid <= 1'h0;
    serRxData <= ~d;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rd(ssidr_pkg::OFF_STATUS, 32'h0000_0030);
    rd(ssidr_pkg::OFF_IRQMASK, '0);
    rd(8'h40, '0);
    `CHK(irq, 1'h0)
    `CHK(selectLines, 4'hE)
  endtask
  task automatic t_enable();
    wr(ssidr_pkg::OFF_CTRL, 32'h0000_0003);
    rd(ssidr_pkg::OFF_STATUS, 32'h0000_0030);
    wr(ssidr_pkg::OFF_CTRL, 32'h0000_0001);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
  endtask
  task automatic t_select();
    logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hF};
    logic [3:0] lines [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
    wr(ssidr_pkg::OFF_MODE, 32'h0000_0003);
    foreach (codes[i]) begin
      wr(ssidr_pkg::OFF_TXWORD, {12'h000, codes[i], 16'h1234});
      idle(2);
      `CHK(selectLines, lines[i])
      `CHK(serTxWord, {12'h000, codes[i], 16'h1234})
      `CHK(serTxValid, 1'h1)
    end
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0030);
    wr(ssidr_pkg::OFF_MODE, 32'h0000_0007);
    wr(ssidr_pkg::OFF_TXWORD, 32'h000A_0000);
    idle(2);
    `CHK(selectLines, 4'hA)
    wr(ssidr_pkg::OFF_MODE, 32'h0005_0001);
    wr(ssidr_pkg::OFF_TXWORD, 32'h0000_0000);
    idle(2);
    `CHK(selectLines, 4'hD)
    `CHK(selectOen, 1'h0)
    serOn <= 1'h1;
    idle(8);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
  endtask
  task automatic t_fault();
    primarySelectInN <= 1'h0;
    idle(8);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0036);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
    primarySelectInN <= 1'h1;
    idle(4);
  endtask
  task automatic t_rx();
    wr(ssidr_pkg::OFF_MODE, '0);
    pulse(16'hBEEF);
    idle(1);
    `CHK(rxReq, 1'h0)
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0033);
    rd(ssidr_pkg::OFF_RXWORD, 32'h0000_BEEF);
    pulse(16'h00A1);
    pulse(16'h00A2);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_003B);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0033);
    rd(ssidr_pkg::OFF_RXWORD, 32'h0000_00A2);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
  endtask
  task automatic t_irq();
    wr(ssidr_pkg::OFF_IRQEN, 32'h0000_003F);
    rd(ssidr_pkg::OFF_IRQMASK, 32'h0000_003F);
    idle(2);
    `CHK(irq, 1'h1)
    wr(ssidr_pkg::OFF_IRQDIS, 32'h0000_003E);
    rd(ssidr_pkg::OFF_IRQMASK, 32'h0000_0001);
    wr(ssidr_pkg::OFF_IRQEN, '0);
    rd(ssidr_pkg::OFF_IRQMASK, 32'h0000_0001);
    idle(2);
    `CHK(irq, 1'h0)
    pulse(16'h0055);
    idle(3);
    `CHK(irq, 1'h1)
    rd(ssidr_pkg::OFF_RXWORD, 32'h0000_0055);
    idle(2);
    `CHK(irq, 1'h0)
    wr(ssidr_pkg::OFF_IRQDIS, 32'h0000_0001);
    rd(ssidr_pkg::OFF_IRQMASK, '0);
  endtask
  task automatic t_rxchan();
    lag <= 4'h3;
    wr(ssidr_pkg::OFF_RXADDR, 32'h0000_1000);
    wr(ssidr_pkg::OFF_RXCOUNT, 32'h0000_0002);
    rd(ssidr_pkg::OFF_RXADDR, 32'h0000_1000);
    pulse(16'h0101);
    idle(12);
    rd(ssidr_pkg::OFF_RXCOUNT, 32'h0000_0001);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0022);
    pulse(16'h0202);
    idle(12);
    `CHK(rxAddr, 32'h0000_1002)
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
    pulse(16'h0303);
    idle(12);
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0033);
    `CHK(rxWord, 32'h0000_0303)
    rd(ssidr_pkg::OFF_RXWORD, 32'h0000_0303);
  endtask
  task automatic t_txchan();
    lag <= 4'h0;
    wr(ssidr_pkg::OFF_TXADDR, 32'h0000_2000);
    wr(ssidr_pkg::OFF_TXCOUNT, 32'h0000_0003);
    idle(40);
    rd(ssidr_pkg::OFF_TXADDR, 32'h0000_2003);
    rd(ssidr_pkg::OFF_TXCOUNT, '0);
    `CHK(serTxWord[15:0], 16'hC302)
    `CHK(txAddr, 32'h0000_2003)
    `CHK(txReq, 1'h0)
    `CHK(serTxValid, 1'h0)
    rd(ssidr_pkg::OFF_STATUS, 32'h0001_0032);
    wr(ssidr_pkg::OFF_CTRL, 32'h0000_0002);
    rd(ssidr_pkg::OFF_STATUS, 32'h0000_0030);
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'h1;
    t_reset();
    t_enable();
    t_select();
    t_fault();
    t_rx();
    t_irq();
    t_rxchan();
    t_txchan();
    conclude();
  end
endmodule

// >>> ssidr_dma_chan.sv
// Purpose: One transfer channel with buffer pointer and buffer counter
// Assumes: ack is honoured only while req is high
// Notes: Bus load wins over a same-cycle transfer
`timescale 1ns/1ns
module ssidr_dma_chan #(
  parameter logic [31:0] STEP = ssidr_pkg::PTR_STEP
) (
  input wire logic core_clk,
  input wire logic resetn,
  ssidr_chan_if.chan ch
);
  logic xfer;

  // Request while triggered and counter nonzero
  assign ch.req = ch.trigger && (ch.cnt != 16'h0000); // see R17 see R19
  assign ch.done = (ch.cnt == 16'h0000); // see R18
  assign xfer = ch.ack && ch.req;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ch.ptr <= ssidr_pkg::RST_WORD;
    end else if (ch.ptrWe) begin
      ch.ptr <= ch.wrData; // see R16
    end else if (xfer) begin
      ch.ptr <= ch.ptr + STEP; // see R18
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ch.cnt <= 16'h0000;
    end else if (ch.cntWe) begin
      ch.cnt <= ch.wrData[15:0];
    end else if (xfer) begin
      ch.cnt <= ch.cnt - 16'h0001; // see R18
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_chan_count_step: assert property (xfer && !ch.cntWe |=> ch.cnt == $past(ch.cnt) - 16'h0001) // see R18
    else $error("channel counter did not step down");
  a_chan_zero_hold: assert property (ch.cnt == 16'h0000 |-> !ch.req) // see R17
    else $error("channel requested with zero count");
endmodule

// >>> ssidr_far_model.sv
// Purpose: Far side stand-in for both transfer channels and the serializer
// Assumes: Requests are levels, answers are one-cycle pulses
// Notes: lag sets how many cycles each answer waits
`timescale 1ns/1ns
module ssidr_far_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [3:0] lag,
  input wire logic serOn,
  input wire logic rxReq,
  output logic rxAck,
  input wire logic txReq,
  output logic txAck,
  output logic [31:0] txData,
  input wire logic serTxValid,
  output logic serTxTaken
);
  logic [3:0] rxWait;
  logic [3:0] txWait;
  logic [3:0] serWait;
  logic [15:0] seq;
  ////////////////////////////////////////////////////////////////////////////
  // Receive channel takes the word
  always_ff @(posedge core_clk) begin
    if (!resetn || rxAck || !rxReq) begin
      rxAck <= 1'h0;
      rxWait <= 4'h0;
    end else if (rxWait >= lag) begin
      rxAck <= 1'h1;
    end else begin
      rxWait <= rxWait + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmit channel hands over words
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txAck <= 1'h0;
      txWait <= 4'h0;
      txData <= 32'h0000_0000;
      seq <= 16'h0000;
    end else if (txAck || !txReq) begin
      txAck <= 1'h0;
      txWait <= 4'h0;
      txData <= ~txData;
    end else if (txWait >= lag) begin
      txAck <= 1'h1;
      txData <= {16'h0000, 16'hC300 ^ seq};
      seq <= seq + 16'h0001;
    end else begin
      txWait <= txWait + 4'h1;
      txData <= ~txData;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Serializer takes the pending word
  always_ff @(posedge core_clk) begin
    if (!resetn || serTxTaken || !serTxValid || !serOn) begin
      serTxTaken <= 1'h0;
      serWait <= 4'h0;
    end else if (serWait >= lag) begin
      serTxTaken <= 1'h1;
    end else begin
      serWait <= serWait + 4'h1;
    end
  end
endmodule

// >>> ssidr_pkg.sv
// Purpose: Shared constants for the serial unit status, mask and channel block
// Assumes: 32-bit Wishbone data, byte offsets on 4-byte boundaries
// Notes: Offsets, field positions and reset values live here only
package ssidr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PTR_W = 32;
  localparam int CNT_W = 16;
  localparam int FLAG_W = 6;
  localparam int CODE_W = 4;
  localparam int WORD_W = 16;

  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_RXWORD = 8'h08;
  localparam logic [7:0] OFF_TXWORD = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQEN = 8'h14;
  localparam logic [7:0] OFF_IRQDIS = 8'h18;
  localparam logic [7:0] OFF_IRQMASK = 8'h1C;
  localparam logic [7:0] OFF_RXADDR = 8'h20;
  localparam logic [7:0] OFF_RXCOUNT = 8'h24;
  localparam logic [7:0] OFF_TXADDR = 8'h28;
  localparam logic [7:0] OFF_TXCOUNT = 8'h2C;

  // Control register fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_DISABLE = 1;

  // Mode register fields
  localparam int MODE_MASTER = 0;
  localparam int MODE_VARSEL = 1;
  localparam int MODE_EXTDEC = 2;
  localparam int MODE_CODE_LSB = 16;

  // Transmit and receive word fields
  localparam int CODE_LSB = 16;

  // Status flag positions
  localparam int FLAG_RXFULL = 0;
  localparam int FLAG_TXEMPTY = 1;
  localparam int FLAG_MODEFAULT = 2;
  localparam int FLAG_OVERRUN = 3;
  localparam int FLAG_RXDONE = 4;
  localparam int FLAG_TXDONE = 5;
  localparam int STAT_ENABLED = 16;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [5:0] RST_MASK = 6'h00;
  localparam logic [3:0] RST_CODE = 4'h0;
  localparam logic [3:0] SEL_NONE = 4'hF;
  localparam logic [31:0] PTR_STEP = 32'h0000_0001;
endpackage

// >>> ssidr_sel_decode.sv
// Purpose: Turns a peripheral select code into four active-low select lines, or passes the code straight out with external decode
// Assumes: Pure combinational
// Notes: Code 1111 without external decode selects nothing
`timescale 1ns/1ns
module ssidr_sel_decode (
  input wire logic [3:0] code,
  input wire logic extDecode,
  output logic [3:0] lines
);
  always_comb begin
    lines = ssidr_pkg::SEL_NONE;
    if (extDecode) begin
      lines = code; // see R4
    end else if (!code[0]) begin
      lines = 4'hE; // see R3
    end else if (!code[1]) begin
      lines = 4'hD;
    end else if (!code[2]) begin
      lines = 4'hB;
    end else if (!code[3]) begin
      lines = 4'h7;
    end else begin
      lines = ssidr_pkg::SEL_NONE;
    end
  end
endmodule
